/* hw/flash_ctrl_defs.vh */
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH

// Register file addresses
`define ADDR_COMMAND      12'hff8
`define ADDR_PAGE_SECTOR  12'hff9
`define ADDR_KHZ_HIGH     12'hffa
`define ADDR_KHZ_LOW      12'hffb

// Command codes
`define CMD_LOCK          8'h00
`define CMD_UNLOCK1       8'h73
`define CMD_UNLOCK2       8'h8c
`define CMD_PAGE_ERASE    8'h95
`define CMD_MASS_ERASE    8'h63
`define CMD_SECTOR_SEL    8'h5e

// Status codes, low three bits of the operation codes carry the step
`define ST_LOCKED         6'h00
`define ST_FIRST          6'h01
`define ST_SECOND         6'h02
`define ST_UNLOCKED       6'h03
`define ST_SECTOR_SEL     6'h04
`define ST_PROG_READ      6'h08
`define ST_PROG_WRITE     6'h09
`define ST_PROG_WAIT      6'h0a
`define ST_ERASE_WAIT     6'h10
`define ST_MASS_WAIT      6'h20

// Field positions
`define PAGE_MSB          6
`define ADDR_PAGE_MSB     15
`define ADDR_PAGE_LSB     9
`define ADDR_SECT_MSB     15
`define ADDR_SECT_LSB     13
`define ERASED_BYTE       8'hff

// Reset values
`define RST_BYTE          8'h00
`define RST_KHZ           16'h0000

// Operation times in microseconds
`define PROG_TIME_US      20'd40
`define ERASE_TIME_US     20'd10000
`define MASS_TIME_US      20'd200000
`define US_PER_MS_KHZ     40'd1000

`endif

/* hw/flash_program_erase_controller.v */
`timescale 1ns/100ps
`include "flash_ctrl_defs.vh"

//Contract
// - Unlocked in-page user write programs byte
// - Programmed byte is old AND new
// - Core stalled during byte program
// - Interrupts deferred until program finishes
// - Command 00h locks and leaves programming
// - No user program in protected sector
// - Out-of-page user writes silently ignored
// - Unlock: 00h, page, 73h, 8Ch, page
// - Page erase fills 512 bytes with FFh
// - Command 95h after unlock erases page
// - Core stalled, interrupts deferred during erase
// - Erase completion relocks automatically
// - Erase only in unprotected sector
// - User code never mass erases
// - Debugger bypasses protection, writes lock bits
// - Debugger: any page, short unlock, page writable
// - Command 63h mass erase only from debugger
// - One open page; new page needs unlock
// - Command and status share one address
// - 5Eh selects lock bits; bad commands lock
// - Status field encodes controller state
// - Page field gives address bits 15:9
// - User code only sets lock bits
// - Timing derived from kHz frequency value
module flash_program_erase_controller #(
  parameter [19:0] PROG_TIME_US  = `PROG_TIME_US,
  parameter [19:0] ERASE_TIME_US = `ERASE_TIME_US,
  parameter [19:0] MASS_TIME_US  = `MASS_TIME_US
) (
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [11:0] reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output wire [7:0]  reg_rdata_o,
  input  wire        mem_wr_i,
  input  wire [15:0] mem_addr_i,
  input  wire [7:0]  mem_wdata_i,
  input  wire        dbg_access_i,
  input  wire        write_protect_i,
  output wire        cpu_stall_o,
  output wire        irq_defer_o,
  output wire        arr_rd_o,
  output wire        arr_wr_o,
  output wire        arr_page_erase_o,
  output wire        arr_mass_erase_o,
  output wire [15:0] arr_addr_o,
  output wire [7:0]  arr_wdata_o,
  input  wire [7:0]  arr_rdata_i
);

  // State and captured values
  reg  [5:0]  state_r;
  reg  [5:0]  state_nxt;
  reg  [6:0]  page_selector_r;
  reg  [6:0]  page_selector_nxt;
  reg  [15:0] clock_khz_value_r;
  reg  [15:0] clock_khz_value_nxt;
  reg  [7:0]  prog_data_r;
  reg  [7:0]  prog_data_nxt;
  reg  [7:0]  rdata_r;
  reg  [7:0]  rdata_nxt;
  reg         stall_r;
  reg         arr_rd_r;
  reg         arr_rd_nxt;
  reg         arr_wr_r;
  reg         arr_wr_nxt;
  reg         arr_page_erase_r;
  reg         arr_page_erase_nxt;
  reg         arr_mass_erase_r;
  reg         arr_mass_erase_nxt;
  reg  [15:0] arr_addr_r;
  reg  [15:0] arr_addr_nxt;
  reg  [7:0]  arr_wdata_r;
  reg  [7:0]  arr_wdata_nxt;
  reg         timer_start;
  reg  [23:0] timer_cycles;
  wire        timer_done;
  wire [7:0]  sector_lock_bits;
  wire        lock_wr;
  wire        busy;
  wire        cmd_wr;
  wire        page_wr;
  wire [7:0]  command_code;
  wire [6:0]  wr_page;

  // Least time rounds up, never below one cycle
  function [23:0] time_cycles;
    input [15:0] khz;
    input [19:0] time_us;
    reg   [39:0] prod;
    reg   [39:0] quot;
    begin
      prod = {24'h000000, khz} * {20'h00000, time_us};
      quot = (prod + `US_PER_MS_KHZ - 40'd1) / `US_PER_MS_KHZ;
      if (quot == 40'd0) begin
        time_cycles = 24'h000001;
      end else if (quot > 40'h0000ffffff) begin
        time_cycles = 24'hffffff;
      end else begin
        time_cycles = quot[23:0];
      end
    end
  endfunction

  // Sector of a page sits in the top three page bits
  function sector_protected;
    input [6:0] page;
    input [7:0] bits;
    begin
      sector_protected = bits[page[`PAGE_MSB:`PAGE_MSB-2]];
    end
  endfunction

  // Register decode
  assign busy         = state_r[5] | state_r[4] | state_r[3];
  assign cmd_wr       = reg_wr_i & ~busy & (reg_addr_i == `ADDR_COMMAND);
  assign page_wr      = reg_wr_i & ~busy & (reg_addr_i == `ADDR_PAGE_SECTOR);
  assign command_code = reg_wdata_i;
  assign wr_page      = reg_wdata_i[`PAGE_MSB:0];
  // Lock bits take the shared address only while selected
  assign lock_wr      = page_wr & (state_r == `ST_SECTOR_SEL);

  // Combined permission for program and page erase
  wire user_blocked   = ~dbg_access_i & write_protect_i;
  wire page_in_prot   = sector_protected(page_selector_r, sector_lock_bits);
  wire mem_page_prot  = sector_protected(mem_addr_i[`ADDR_PAGE_MSB:`ADDR_PAGE_LSB],
                                         sector_lock_bits);
  wire in_open_page   = (mem_addr_i[`ADDR_PAGE_MSB:`ADDR_PAGE_LSB] == page_selector_r);
  // Debugger may program anywhere, ignoring lock bits
  wire prog_ok        = dbg_access_i | (in_open_page & ~mem_page_prot & ~user_blocked);
  wire erase_ok       = dbg_access_i | (~page_in_prot & ~user_blocked);

  // Sequencer; any command or page write out of order relocks
  always @* begin
    state_nxt          = state_r;
    page_selector_nxt  = page_selector_r;
    prog_data_nxt      = prog_data_r;
    arr_rd_nxt         = 1'b0;
    arr_wr_nxt         = 1'b0;
    arr_page_erase_nxt = 1'b0;
    arr_mass_erase_nxt = 1'b0;
    arr_addr_nxt       = arr_addr_r;
    arr_wdata_nxt      = arr_wdata_r;
    timer_start        = 1'b0;
    timer_cycles       = time_cycles(clock_khz_value_r, PROG_TIME_US);
    case (state_r)
      `ST_LOCKED: begin
        if (cmd_wr) begin
          if (command_code == `CMD_UNLOCK1) begin
            state_nxt = `ST_FIRST;
          end else if (command_code == `CMD_SECTOR_SEL) begin
            state_nxt = `ST_SECTOR_SEL;
          end else begin
            state_nxt = `ST_LOCKED;
          end
        end else if (page_wr) begin
          page_selector_nxt = wr_page;
        end
      end
      `ST_FIRST: begin
        if (cmd_wr && command_code == `CMD_UNLOCK2) begin
          // Debugger skips the page rewrite
          state_nxt = dbg_access_i ? `ST_UNLOCKED : `ST_SECOND;
        end else if (cmd_wr || page_wr) begin
          state_nxt = `ST_LOCKED;
        end
      end
      `ST_SECOND: begin
        if (page_wr && wr_page == page_selector_r) begin
          state_nxt = `ST_UNLOCKED;
        end else if (cmd_wr || page_wr) begin
          state_nxt = `ST_LOCKED;
        end
      end
      `ST_UNLOCKED: begin
        if (cmd_wr) begin
          if (command_code == `CMD_PAGE_ERASE && erase_ok) begin
            // Erase of the page held in the page field
            arr_addr_nxt       = {page_selector_r, 9'h000};
            arr_page_erase_nxt = 1'b1;
            timer_start        = 1'b1;
            timer_cycles       = time_cycles(clock_khz_value_r, ERASE_TIME_US);
            state_nxt          = `ST_ERASE_WAIT;
          end else if (command_code == `CMD_MASS_ERASE && dbg_access_i) begin
            arr_addr_nxt       = 16'h0000;
            arr_mass_erase_nxt = 1'b1;
            timer_start        = 1'b1;
            timer_cycles       = time_cycles(clock_khz_value_r, MASS_TIME_US);
            state_nxt          = `ST_MASS_WAIT;
          end else begin
            // Covers 00h, user mass erase and refused erases
            state_nxt = `ST_LOCKED;
          end
        end else if (page_wr) begin
          if (dbg_access_i) begin
            page_selector_nxt = wr_page;
          end else begin
            state_nxt = `ST_LOCKED;
          end
        end else if (mem_wr_i && prog_ok) begin
          // Fetch the old byte first so only ones can clear
          arr_addr_nxt  = mem_addr_i;
          prog_data_nxt = mem_wdata_i;
          arr_rd_nxt    = 1'b1;
          state_nxt     = `ST_PROG_READ;
        end
      end
      `ST_SECTOR_SEL: begin
        // Any command but 5Eh deselects; 5Eh keeps selection
        if (cmd_wr) begin
          state_nxt = (command_code == `CMD_SECTOR_SEL) ? `ST_SECTOR_SEL
                                                        : `ST_LOCKED;
        end
      end
      `ST_PROG_READ: begin
        state_nxt = `ST_PROG_WRITE;
      end
      `ST_PROG_WRITE: begin
        arr_wdata_nxt = arr_rdata_i & prog_data_r;
        arr_wr_nxt    = 1'b1;
        timer_start   = 1'b1;
        state_nxt     = `ST_PROG_WAIT;
      end
      `ST_PROG_WAIT: begin
        if (timer_done) begin
          state_nxt = `ST_UNLOCKED;
        end
      end
      `ST_ERASE_WAIT: begin
        if (timer_done) begin
          state_nxt = `ST_LOCKED;
        end
      end
      `ST_MASS_WAIT: begin
        if (timer_done) begin
          state_nxt = `ST_LOCKED;
        end
      end
      default: begin
        state_nxt = `ST_LOCKED;
      end
    endcase
  end

  // Frequency bytes stay writable whatever the state
  always @* begin
    clock_khz_value_nxt = clock_khz_value_r;
    if (reg_wr_i && reg_addr_i == `ADDR_KHZ_HIGH) begin
      clock_khz_value_nxt = {reg_wdata_i, clock_khz_value_r[7:0]};
    end else if (reg_wr_i && reg_addr_i == `ADDR_KHZ_LOW) begin
      clock_khz_value_nxt = {clock_khz_value_r[15:8], reg_wdata_i};
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      if (reg_addr_i == `ADDR_COMMAND) begin
        rdata_nxt = {2'b00, state_r};
      end else if (reg_addr_i == `ADDR_PAGE_SECTOR) begin
        if (state_r == `ST_SECTOR_SEL) begin
          rdata_nxt = sector_lock_bits;
        end else begin
          rdata_nxt = {1'b0, page_selector_r};
        end
      end else if (reg_addr_i == `ADDR_KHZ_HIGH) begin
        rdata_nxt = clock_khz_value_r[15:8];
      end else if (reg_addr_i == `ADDR_KHZ_LOW) begin
        rdata_nxt = clock_khz_value_r[7:0];
      end else begin
        rdata_nxt = `RST_BYTE;
      end
    end
  end

  // Stall flag follows the next state so it rises with the operation
  wire stall_nxt = state_nxt[5] | state_nxt[4] | state_nxt[3];

  // Registers; lock state after reset
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r           <= `ST_LOCKED;
      page_selector_r   <= 7'h00;
      clock_khz_value_r <= `RST_KHZ;
      prog_data_r       <= `RST_BYTE;
      rdata_r           <= `RST_BYTE;
      stall_r           <= 1'b0;
      arr_rd_r          <= 1'b0;
      arr_wr_r          <= 1'b0;
      arr_page_erase_r  <= 1'b0;
      arr_mass_erase_r  <= 1'b0;
      arr_addr_r        <= 16'h0000;
      arr_wdata_r       <= `ERASED_BYTE;
    end else begin
      state_r           <= state_nxt;
      page_selector_r   <= page_selector_nxt;
      clock_khz_value_r <= clock_khz_value_nxt;
      prog_data_r       <= prog_data_nxt;
      rdata_r           <= rdata_nxt;
      stall_r           <= stall_nxt;
      arr_rd_r          <= arr_rd_nxt;
      arr_wr_r          <= arr_wr_nxt;
      arr_page_erase_r  <= arr_page_erase_nxt;
      arr_mass_erase_r  <= arr_mass_erase_nxt;
      arr_addr_r        <= arr_addr_nxt;
      arr_wdata_r       <= arr_wdata_nxt;
    end
  end

  // Protection bits, set-only from user code
  sector_lock_unit u_sector_lock (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .wr_i      (lock_wr),
    .dbg_i     (dbg_access_i),
    .wdata_i   (reg_wdata_i),
    .bits_o    (sector_lock_bits)
  );

  // One timer shared by all operations, they never overlap
  op_timer u_op_timer (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (timer_start),
    .cycles_i  (timer_cycles),
    .done_o    (timer_done)
  );

  // Outputs straight from flops
  assign reg_rdata_o      = rdata_r;
  assign cpu_stall_o      = stall_r;
  assign irq_defer_o      = stall_r;
  assign arr_rd_o         = arr_rd_r;
  assign arr_wr_o         = arr_wr_r;
  assign arr_page_erase_o = arr_page_erase_r;
  assign arr_mass_erase_o = arr_mass_erase_r;
  assign arr_addr_o       = arr_addr_r;
  assign arr_wdata_o      = arr_wdata_r;

endmodule // flash_program_erase_controller

/* hw/op_timer.v */
`timescale 1ns/100ps

module op_timer (
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  input  wire        start_i,
  input  wire [23:0] cycles_i,
  output wire        done_o
);

  reg  [23:0] count_r;
  reg         busy_r;
  reg         done_r;

  // Counts the loaded cycles, then pulses done for one cycle
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= 24'h000000;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start_i) begin
        count_r <= cycles_i;
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        if (count_r <= 24'h000001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          count_r <= count_r - 24'h000001;
        end
      end
    end
  end

  assign done_o = done_r;

endmodule // op_timer

/* hw/sector_lock_unit.v */
`timescale 1ns/100ps
`include "flash_ctrl_defs.vh"

module sector_lock_unit (
  input  wire       sys_clk_i,
  input  wire       resetn_i,
  input  wire       wr_i,
  input  wire       dbg_i,
  input  wire [7:0] wdata_i,
  output wire [7:0] bits_o
);

  reg  [7:0] bits_r;
  wire [7:0] bits_nxt;

  // User code may only add protection; debugger may write either value
  assign bits_nxt = dbg_i ? wdata_i : (bits_r | wdata_i);

  // Cleared by reset; a debugger write loads the written byte
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bits_r <= `RST_BYTE;
    end else if (wr_i) begin
      bits_r <= bits_nxt;
    end
  end

  assign bits_o = bits_r;

endmodule // sector_lock_unit

/* sim/flash_array_model.sv */
`timescale 1ns/100ps
module flash_array_model (
  input  wire        sys_clk_i,
  input  wire        rd_i,
  input  wire        wr_i,
  input  wire        page_erase_i,
  input  wire        mass_erase_i,
  input  wire [15:0] addr_i,
  input  wire [7:0]  wdata_i,
  output reg  [7:0]  rdata_o
);
  reg [7:0] mem [0:65535];
  integer   i;
  integer   j;
  // Non-erased pattern so that an erase shows up
  initial begin
    rdata_o = 8'h00;
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5a;
  end
  // Read data is valid one cycle only, then scrambled to catch late sampling
  always @(posedge sys_clk_i) begin
    if (rd_i)
      rdata_o <= mem[addr_i];
    else
      rdata_o <= ~rdata_o;
    if (wr_i)
      mem[addr_i] <= wdata_i;
    if (page_erase_i)
      for (j = 0; j < 512; j = j + 1)
        mem[{addr_i[15:9], j[8:0]}] <= 8'hff;
    if (mass_erase_i)
      for (j = 0; j < 65536; j = j + 1)
        mem[j] <= 8'hff;
  end
endmodule // flash_array_model

/* sim/flash_ctrl_checker.sv */
`timescale 1ns/100ps
module flash_ctrl_checker (
  input wire        sys_clk_i,
  input wire        resetn_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [11:0] reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire [7:0]  reg_rdata_o,
  input wire        mem_wr_i,
  input wire [15:0] mem_addr_i,
  input wire        dbg_access_i,
  input wire        write_protect_i,
  input wire        cpu_stall_o,
  input wire        irq_defer_o,
  input wire        arr_rd_o,
  input wire        arr_wr_o,
  input wire        arr_page_erase_o,
  input wire        arr_mass_erase_o,
  input wire [15:0] arr_addr_o,
  input wire [7:0]  arr_wdata_o,
  input wire [7:0]  arr_rdata_i
);
  // One domain, so one clock and one reset serve every property
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Any array activity must already have the core stalled and interrupts held
  chk_defer_tracks_stall: assert property (irq_defer_o == cpu_stall_o && (cpu_stall_o
      || !(arr_rd_o || arr_wr_o || arr_page_erase_o || arr_mass_erase_o)))
    else $error("interrupt defer differs from core stall");
  chk_read_then_write: assert property (arr_rd_o |-> cpu_stall_o ##2 arr_wr_o)
    else $error("program write missing two cycles after read");
  chk_program_cause: assert property (arr_rd_o |-> $past(mem_wr_i) && arr_addr_o == $past(mem_addr_i))
    else $error("array read without matching core write");
  chk_only_clears: assert property (arr_wr_o |-> (arr_wdata_o & ~$past(arr_rdata_i)) == 8'h00)
    else $error("program data sets a bit");
  chk_option_blocks: assert property (arr_rd_o && !$past(dbg_access_i) |-> !$past(write_protect_i))
    else $error("user program despite write protect");
  chk_erase_cause: assert property (arr_page_erase_o |-> $past(reg_wr_i && reg_addr_i == 12'hff8 && reg_wdata_i == 8'h95) && arr_addr_o[8:0] == 9'h000 && cpu_stall_o)
    else $error("page erase without erase command");
  chk_mass_debug: assert property (arr_mass_erase_o |-> $past(dbg_access_i && reg_wr_i && reg_wdata_i == 8'h63))
    else $error("mass erase outside debugger access");
  chk_stall_bounded: assert property ($rose(cpu_stall_o) |-> ##[1:200] !cpu_stall_o)
    else $error("operation never ends");
  chk_status_busy: assert property (reg_rd_i && reg_addr_i == 12'hff8 && cpu_stall_o |=> reg_rdata_o[5:3] != 3'h0)
    else $error("status idle while core stalled");
  chk_reserved_zero: assert property (reg_rd_i && reg_addr_i == 12'hff8 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("reserved status bits set");
  // Main traffic seen at the array side
  cover property (arr_wr_o);
  cover property (arr_page_erase_o);
  cover property (arr_mass_erase_o);
endmodule // flash_ctrl_checker

bind flash_program_erase_controller flash_ctrl_checker chk_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i), .dbg_access_i(dbg_access_i),
  .write_protect_i(write_protect_i), .cpu_stall_o(cpu_stall_o), .irq_defer_o(irq_defer_o),
  .arr_rd_o(arr_rd_o), .arr_wr_o(arr_wr_o), .arr_page_erase_o(arr_page_erase_o),
  .arr_mass_erase_o(arr_mass_erase_o), .arr_addr_o(arr_addr_o),
  .arr_wdata_o(arr_wdata_o), .arr_rdata_i(arr_rdata_i));

/* sim/flash_program_erase_controller_tb.sv */
`timescale 1ns/100ps
module flash_program_erase_controller_tb;
  reg         sys_clk_i;
  reg         resetn_i;
  reg         reg_wr_i;
  reg         reg_rd_i;
  reg  [11:0] reg_addr_i;
  reg  [7:0]  reg_wdata_i;
  wire [7:0]  reg_rdata_o;
  reg         mem_wr_i;
  reg  [15:0] mem_addr_i;
  reg  [7:0]  mem_wdata_i;
  reg         dbg_access_i;
  reg         write_protect_i;
  wire        cpu_stall_o;
  wire        irq_defer_o;
  wire        arr_rd_o;
  wire        arr_wr_o;
  wire        arr_page_erase_o;
  wire        arr_mass_erase_o;
  wire [15:0] arr_addr_o;
  wire [7:0]  arr_wdata_o;
  wire [7:0]  arr_rdata_i;
  integer     bad_count;
  integer     check_count;
  integer     cyc;
  integer     k;
  reg  [39:0] bad_cmds;

  // Short op times: 20/40/60 cycles at 20000 kHz
  flash_program_erase_controller #(.PROG_TIME_US(20'd1), .ERASE_TIME_US(20'd2),
    .MASS_TIME_US(20'd3)) uut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
    .dbg_access_i(dbg_access_i), .write_protect_i(write_protect_i),
    .cpu_stall_o(cpu_stall_o), .irq_defer_o(irq_defer_o), .arr_rd_o(arr_rd_o),
    .arr_wr_o(arr_wr_o), .arr_page_erase_o(arr_page_erase_o),
    .arr_mass_erase_o(arr_mass_erase_o), .arr_addr_o(arr_addr_o),
    .arr_wdata_o(arr_wdata_o), .arr_rdata_i(arr_rdata_i));

  flash_array_model mp (
    .sys_clk_i(sys_clk_i), .rd_i(arr_rd_o), .wr_i(arr_wr_o),
    .page_erase_i(arr_page_erase_o), .mass_erase_i(arr_mass_erase_o),
    .addr_i(arr_addr_o), .wdata_i(arr_wdata_o), .rdata_o(arr_rdata_i));

  // 50 ns clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  function [7:0] pat(input [15:0] a);
    pat = a[7:0] ^ 8'h5a;
  endfunction

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Strobes last one cycle; each task starts on a fresh falling edge
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(negedge sys_clk_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge sys_clk_i);
      reg_wr_i = 1'b0;
    end
  endtask

  task rdm(input [11:0] a, input [7:0] m, input [7:0] e);
    begin
      @(negedge sys_clk_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge sys_clk_i);
      reg_rd_i = 1'b0;
      chk(reg_rdata_o & m, e);
    end
  endtask

  task rd(input [11:0] a, input [7:0] e);
    rdm(a, 8'hff, e);
  endtask

  // Bounded wait for the core stall to drop
  task idle;
    integer n;
    begin
      n = 0;
      while (cpu_stall_o !== 1'b0 && n < 300) begin
        @(negedge sys_clk_i);
        n = n + 1;
      end
    end
  endtask

  task mw(input [15:0] a, input [7:0] d);
    begin
      @(negedge sys_clk_i);
      mem_wr_i = 1'b1;
      mem_addr_i = a;
      mem_wdata_i = d;
      @(negedge sys_clk_i);
      mem_wr_i = 1'b0;
      idle;
    end
  endtask

  task unlock(input [7:0] p);
    begin
      wr(12'hff8, 8'h00);
      wr(12'hff9, p);
      wr(12'hff8, 8'h73);
      wr(12'hff8, 8'h8c);
      wr(12'hff9, p);
    end
  endtask

  // Cycle ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end

  initial begin
    {reg_wr_i, reg_rd_i, mem_wr_i, dbg_access_i, write_protect_i} = 5'h00;
    reg_addr_i = 12'h000;
    reg_wdata_i = 8'h00;
    mem_addr_i = 16'h0000;
    mem_wdata_i = 8'h00;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    bad_cmds = 40'h95635e1200;
    resetn_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    rd(12'hff8, 8'h00);
    rd(12'hff9, 8'h00);
    rd(12'hffe, 8'h00);
    wr(12'hffa, 8'h4e);
    wr(12'hffb, 8'h20);
    rd(12'hffa, 8'h4e);
    rd(12'hffb, 8'h20);
    $display("test reset done");
    // Stepwise unlock then erase of page 05
    wr(12'hff8, 8'h00);
    wr(12'hff9, 8'h05);
    wr(12'hff8, 8'h73);
    rd(12'hff8, 8'h01);
    wr(12'hff8, 8'h8c);
    rd(12'hff8, 8'h02);
    wr(12'hff9, 8'h05);
    rd(12'hff8, 8'h03);
    wr(12'hff8, 8'h95);
    rdm(12'hff8, 8'hf8, 8'h10);
    chk({6'h00, irq_defer_o, cpu_stall_o}, 8'h03);
    idle;
    rd(12'hff8, 8'h00);
    chk(mp.mem[16'h0a00], 8'hff);
    chk(mp.mem[16'h0bff], 8'hff);
    chk(mp.mem[16'h0c00], pat(16'h0c00));
    $display("test erase done");
    // Programming only clears bits, only inside the open page
    unlock(8'h05);
    mw(16'h0a10, 8'h3c);
    chk(mp.mem[16'h0a10], 8'h3c);
    mw(16'h0a10, 8'hf5);
    chk(mp.mem[16'h0a10], 8'h34);
    // Status and stall looked at while a program runs
    mem_addr_i = 16'h0a12;
    mem_wdata_i = 8'h81;
    @(negedge sys_clk_i) mem_wr_i = 1'b1;
    @(negedge sys_clk_i) mem_wr_i = 1'b0;
    rdm(12'hff8, 8'hf8, 8'h08);
    chk({6'h00, irq_defer_o, cpu_stall_o}, 8'h03);
    idle;
    chk(mp.mem[16'h0a12], 8'h81);
    mw(16'h0c00, 8'h00);
    chk(mp.mem[16'h0c00], pat(16'h0c00));
    rd(12'hff8, 8'h03);
    wr(12'hff8, 8'h00);
    rd(12'hff8, 8'h00);
    mw(16'h0a11, 8'h00);
    chk(mp.mem[16'h0a11], 8'hff);
    $display("test program done");
    // Broken sequences fall back to locked
    unlock(8'h05);
    wr(12'hff9, 8'h06);
    rd(12'hff8, 8'h00);
    wr(12'hff8, 8'h00);
    wr(12'hff9, 8'h06);
    wr(12'hff8, 8'h73);
    wr(12'hff8, 8'h8c);
    wr(12'hff9, 8'h07);
    rd(12'hff8, 8'h00);
    for (k = 0; k < 5; k = k + 1) begin
      wr(12'hff8, 8'h73);
      wr(12'hff8, bad_cmds[8*k +: 8]);
      rd(12'hff8, 8'h00);
    end
    $display("test sequence done");
    // Sector 0 locked by user code, cannot be unlocked again
    wr(12'hff8, 8'h5e);
    rd(12'hff8, 8'h04);
    wr(12'hff9, 8'h01);
    wr(12'hff9, 8'h00);
    rd(12'hff9, 8'h01);
    unlock(8'h02);
    mw(16'h0400, 8'h00);
    chk(mp.mem[16'h0400], pat(16'h0400));
    wr(12'hff8, 8'h95);
    rd(12'hff8, 8'h00);
    chk(mp.mem[16'h0401], pat(16'h0401));
    write_protect_i = 1'b1;
    unlock(8'h15);
    mw(16'h2a00, 8'h00);
    chk(mp.mem[16'h2a00], pat(16'h2a00));
    write_protect_i = 1'b0;
    wr(12'hff8, 8'h63);
    rd(12'hff8, 8'h00);
    chk(mp.mem[16'h2a00], pat(16'h2a00));
    $display("test protect done");
    // Debugger: short unlock, any page, mass erase, lock bits cleared
    dbg_access_i = 1'b1;
    wr(12'hff8, 8'h00);
    wr(12'hff9, 8'h01);
    wr(12'hff8, 8'h73);
    wr(12'hff8, 8'h8c);
    rd(12'hff8, 8'h03);
    wr(12'hff9, 8'h03);
    rd(12'hff8, 8'h03);
    mw(16'h0002, 8'h0f);
    chk(mp.mem[16'h0002], pat(16'h0002) & 8'h0f);
    wr(12'hff8, 8'h63);
    rdm(12'hff8, 8'hf8, 8'h20);
    chk({6'h00, irq_defer_o, cpu_stall_o}, 8'h03);
    idle;
    rd(12'hff8, 8'h00);
    chk(mp.mem[16'hffff], 8'hff);
    wr(12'hff8, 8'h5e);
    wr(12'hff9, 8'h00);
    rd(12'hff9, 8'h00);
    $display("test debugger done");
    end_sim;
  end
endmodule // flash_program_erase_controller_tb
